// ===== common/cwts_pkg.sv
// Purpose: Shared constants for the continuous-wave test sequencer pair.
// Assumes: 40 MHz system clock, 8-bit register map on the device side.
// Notes:   Host software registers are 3-bit addressed, device map 8-bit.
package cwts_pkg;
	// Device register offsets
	localparam logic [7:0] RA_STATUS = 8'h01; // Transceiver status
	localparam logic [7:0] RA_CMD    = 8'h02; // State command
	localparam logic [7:0] RA_CHAN   = 8'h08; // Operating channel
	localparam logic [7:0] RA_MASK   = 8'h0E; // Interrupt mask
	localparam logic [7:0] RA_ISTAT  = 8'h0F; // Interrupt status
	localparam logic [7:0] RA_RFCTL  = 8'h16; // Rf control, power and gain
	localparam logic [7:0] RA_TEST   = 8'h1C; // Continuous tx test control
	localparam logic [7:0] RA_CFG_A  = 8'h34; // Test config a
	localparam logic [7:0] RA_CFG_B  = 8'h36; // Test config b
	localparam logic [7:0] RA_CFG_C  = 8'h3F; // Test config c
	// Command and status codes
	localparam logic [7:0] CMD_TX    = 8'h02; // Start transmission
	localparam logic [7:0] CMD_OFF   = 8'h03; // Go to off state
	localparam logic [7:0] CMD_PLL   = 8'h09; // Go to PLL-on state
	localparam logic [7:0] ST_TX     = 8'h02; // Busy transmit
	localparam logic [7:0] ST_OFF    = 8'h08; // Off state
	localparam logic [7:0] ST_PLL    = 8'h09; // PLL-on, locked
	localparam logic [7:0] ST_BUSY   = 8'h1F; // Synthesizer settling
	// Sequence values and reset values
	localparam logic [7:0] MASK_VAL  = 8'h01; // Lock interrupt only
	localparam logic [7:0] LOCK_BIT  = 8'h01; // Lock status value
	localparam logic [7:0] TEST_OFF  = 8'h00; // Test mode off
	localparam logic [7:0] TEST_V1   = 8'h54; // First test control write
	localparam logic [7:0] TEST_V2   = 8'h42; // Second test control write
	localparam logic [7:0] CFG_A_VAL = 8'h00; // Config a value
	localparam logic [7:0] CFG_B_VAL = 8'h0F; // Config b value
	localparam logic [7:0] CFG_C_VAL = 8'h08; // Config c value
	localparam logic [7:0] REG_RST   = 8'h00; // Reset value of all regs
	localparam logic [1:0] GAIN_OFFS = 2'h3;  // Tx gain offset field
	// Timing
	localparam int         CLK_NS    = 25;    // Clock period in ns
	localparam int         LOCK_NS   = 1000;  // Synthesizer lock time
	localparam logic [7:0] LOCK_CYC  = 8'((LOCK_NS + CLK_NS - 1) / CLK_NS);
	localparam logic [3:0] DRST_CYC  = 4'h4;  // Device reset pulse length
	// Host software register offsets and interrupt bits
	localparam logic [2:0] HA_CTRL   = 3'h0;  // Bit0 start, bit1 stop
	localparam logic [2:0] HA_CHAN   = 3'h1;  // Channel to program
	localparam logic [2:0] HA_PWR    = 3'h2;  // Power, bits 7:2 used
	localparam logic [2:0] HA_STAT   = 3'h3;  // Sequencer phase
	localparam logic [2:0] HA_ISTAT  = 3'h4;  // Sticky events
	localparam logic [2:0] HA_IMASK  = 3'h5;  // Event mask
	localparam int         EV_TX     = 0;     // Transmission started
	localparam int         EV_DONE   = 1;     // Test finished
	localparam int         EV_ERR    = 2;     // Off state not verified
	// Device radio states
	typedef enum logic [1:0] {
		RADIO_OFF_STATE, PLL_SETTLE, PLL_LOCKED, BUSY_TX
	} cwts_radio_t;
endpackage

// ===== common/cwts_if.sv
// Purpose: Register link between the host sequencer and the device.
// Assumes: Both ends share one clock; read data one cycle after strobe.
// Notes:   All signals are registered at their source.
`timescale 1ns/100ps
`default_nettype none
interface cwts_if;
	logic [7:0] addr;    // Register address
	logic [7:0] wdata;   // Write data
	logic       wr;      // Write strobe
	logic       rd;      // Read strobe
	logic       dev_rst; // Device soft reset, level
	logic [7:0] rdata;   // Read data, cycle after rd
	logic       irq;     // Device interrupt, level
	// Device end
	modport dev (input addr, wdata, wr, rd, dev_rst, output rdata, irq);
	// Host end
	modport host (output addr, wdata, wr, rd, dev_rst, input rdata, irq);
endinterface
`default_nettype wire

// ===== verilog/cwts_device.sv
// Purpose: Device end: test registers, radio state and lock interrupt.
// Assumes: Host keeps the documented order of accesses.
// Notes:   Unmapped reads return zero; unmapped writes are dropped.
`timescale 1ns/100ps
`default_nettype none
module cwts_device (
	input  wire logic        i_sys_clk,
	input  wire logic        i_rst_n,
	cwts_if.dev              bus,
	output logic             o_cw_active,
	output logic [7:0]       o_channel,
	output cwts_pkg::cwts_radio_t o_radio_state
);
	import cwts_pkg::*;

	cwts_radio_t st_reg, st_next;          // Radio state
	logic [7:0]  cnt_reg, cnt_next;        // Lock timer
	logic [7:0]  mask_reg, mask_next;      // Interrupt mask
	logic [7:0]  istat_reg, istat_next;    // Interrupt status
	logic [7:0]  test_reg, test_next;      // Test control
	logic [7:0]  cfga_reg, cfga_next;      // Config a
	logic [7:0]  cfgb_reg, cfgb_next;      // Config b
	logic [7:0]  cfgc_reg, cfgc_next;      // Config c
	logic [7:0]  chan_reg, chan_next;      // Channel
	logic [7:0]  rfc_reg, rfc_next;        // Power and gain offset
	logic [7:0]  rd_reg, rd_next;          // Read data
	logic        irq_reg, irq_next;        // Interrupt line
	logic        cw_reg, cw_next;          // Carrier on
	logic [7:0]  stat_code;                // Status code of state
	logic        lock_ev;                  // Lock event this cycle

	// Status code shown for each state
	always_comb begin
		case (st_reg)
			RADIO_OFF_STATE: stat_code = ST_OFF;
			PLL_SETTLE:      stat_code = ST_BUSY;
			PLL_LOCKED:      stat_code = ST_PLL;
			BUSY_TX:         stat_code = ST_TX;
			default:         stat_code = ST_OFF;
		endcase
	end

	// Next values of state and registers
	always_comb begin
		st_next    = st_reg;
		cnt_next   = cnt_reg;
		mask_next  = mask_reg;
		test_next  = test_reg;
		cfga_next  = cfga_reg;
		cfgb_next  = cfgb_reg;
		cfgc_next  = cfgc_reg;
		chan_next  = chan_reg;
		rfc_next   = rfc_reg;
		rd_next    = REG_RST;
		lock_ev    = 1'b0;
		// Lock timer runs while settling
		if (st_reg == PLL_SETTLE) begin
			if (cnt_reg <= 8'h01) begin
				st_next = PLL_LOCKED;
				lock_ev = 1'b1;
			end else begin
				cnt_next = cnt_reg - 8'h01;
			end
		end
		// Register writes
		if (bus.wr) begin
			case (bus.addr)
				RA_CMD: begin
					if (bus.wdata == CMD_OFF) begin
						st_next = RADIO_OFF_STATE;
					end else if (bus.wdata == CMD_PLL
						&& st_reg == RADIO_OFF_STATE) begin
						st_next  = PLL_SETTLE;
						cnt_next = LOCK_CYC;
					end else if (bus.wdata == CMD_TX
						&& st_reg == PLL_LOCKED) begin
						st_next = BUSY_TX;
					end
				end
				RA_MASK:  mask_next = bus.wdata;
				RA_CHAN:  chan_next = bus.wdata;
				RA_RFCTL: rfc_next  = bus.wdata;
				RA_TEST: begin
					test_next = bus.wdata;
					// Clearing test mode drops the carrier
					if (bus.wdata == TEST_OFF && st_reg == BUSY_TX) begin
						st_next = PLL_LOCKED;
					end
				end
				RA_CFG_A: cfga_next = bus.wdata;
				RA_CFG_B: cfgb_next = bus.wdata;
				RA_CFG_C: cfgc_next = bus.wdata;
				default: ;                           // Dropped
			endcase
		end
		// Register reads
		if (bus.rd) begin
			case (bus.addr)
				RA_STATUS: rd_next = stat_code;
				RA_CMD:    rd_next = stat_code;
				RA_MASK:   rd_next = mask_reg;
				RA_ISTAT:  rd_next = istat_reg;
				RA_CHAN:   rd_next = chan_reg;
				RA_RFCTL:  rd_next = rfc_reg;
				RA_TEST:   rd_next = test_reg;
				RA_CFG_A:  rd_next = cfga_reg;
				RA_CFG_B:  rd_next = cfgb_reg;
				RA_CFG_C:  rd_next = cfgc_reg;
				default:   rd_next = REG_RST;
			endcase
		end
		// Status clears on read, a new lock event wins
		istat_next = istat_reg;
		if (bus.rd && bus.addr == RA_ISTAT) begin
			istat_next = REG_RST;
		end
		if (lock_ev) begin
			istat_next = istat_next | LOCK_BIT;
		end
		irq_next = |(istat_next & mask_next);
		cw_next  = (st_next == BUSY_TX) && (test_next != TEST_OFF);
		// Host-driven soft reset returns all but the read data register to reset state
		if (bus.dev_rst) begin
			st_next    = RADIO_OFF_STATE;
			cnt_next   = REG_RST;
			mask_next  = REG_RST;
			istat_next = REG_RST;
			test_next  = REG_RST;
			cfga_next  = REG_RST;
			cfgb_next  = REG_RST;
			cfgc_next  = REG_RST;
			chan_next  = REG_RST;
			rfc_next   = REG_RST;
			irq_next   = 1'b0;
			cw_next    = 1'b0;
		end
	end

	// Register stage
	always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			st_reg    <= RADIO_OFF_STATE;
			cnt_reg   <= REG_RST;
			mask_reg  <= REG_RST;
			istat_reg <= REG_RST;
			test_reg  <= REG_RST;
			cfga_reg  <= REG_RST;
			cfgb_reg  <= REG_RST;
			cfgc_reg  <= REG_RST;
			chan_reg  <= REG_RST;
			rfc_reg   <= REG_RST;
			rd_reg    <= REG_RST;
			irq_reg   <= 1'b0;
			cw_reg    <= 1'b0;
		end else begin
			st_reg    <= st_next;
			cnt_reg   <= cnt_next;
			mask_reg  <= mask_next;
			istat_reg <= istat_next;
			test_reg  <= test_next;
			cfga_reg  <= cfga_next;
			cfgb_reg  <= cfgb_next;
			cfgc_reg  <= cfgc_next;
			chan_reg  <= chan_next;
			rfc_reg   <= rfc_next;
			rd_reg    <= rd_next;
			irq_reg   <= irq_next;
			cw_reg    <= cw_next;
		end
	end

	// Outputs straight from flops
	assign bus.rdata     = rd_reg;
	assign bus.irq       = irq_reg;
	assign o_cw_active   = cw_reg;
	assign o_channel     = chan_reg;
	assign o_radio_state = st_reg;
endmodule
`default_nettype wire

// ===== verilog/cwts_host.sv
// Purpose: Host end: runs the continuous-wave test sequence on the device.
// Assumes: Software starts, stops and watches it through a small port.
// Notes:   One device access per step; reads are checked a cycle later.
//
// Chosen here: the address-and-strobe port.
`timescale 1ns/100ps
`default_nettype none
module cwts_host (
	input  wire logic        i_sys_clk,
	input  wire logic        i_rst_n,
	cwts_if.host             bus,
	input  wire logic [2:0]  i_addr,
	input  wire logic [7:0]  i_wdata,
	input  wire logic        i_wr,
	input  wire logic        i_rd,
	output logic [7:0]       o_rdata,
	output logic             o_irq
);
	import cwts_pkg::*;

	// Sequencer phases
	typedef enum logic [2:0] {
		H_IDLE, H_ISSUE, H_CHECK, H_TX, H_RST
	} cwts_hphase_t;

	// Step numbers of the access list
	localparam logic [3:0] S_VERIFY = 4'd4;   // Off-state check read
	localparam logic [3:0] S_POLL   = 4'd11;  // Lock status poll read
	localparam logic [3:0] S_LAST   = 4'd12;  // Transmit start write

	cwts_hphase_t ph_reg, ph_next;        // Sequencer phase
	logic [3:0]   step_reg, step_next;    // Access list position
	logic [3:0]   rcnt_reg, rcnt_next;    // Device reset timer
	logic [7:0]   chan_reg, chan_next;    // Software channel
	logic [7:0]   pwr_reg, pwr_next;      // Software power
	logic [7:0]   pwrl_reg, pwrl_next;    // Power latched at start
	logic [2:0]   ist_reg, ist_next;      // Sticky events
	logic [2:0]   imask_reg, imask_next;  // Event mask
	logic [7:0]   ord_reg, ord_next;      // Software read data
	logic         irq_reg, irq_next;      // Interrupt line
	logic [7:0]   a_reg, a_next;          // Device address
	logic [7:0]   d_reg, d_next;          // Device write data
	logic         wr_reg, wr_next;        // Device write strobe
	logic         rd_reg, rd_next;        // Device read strobe
	logic         drst_reg, drst_next;    // Device reset
	logic         s_rd;                   // Current step is a read
	logic [7:0]   s_addr;                 // Current step address
	logic [7:0]   s_data;                 // Current step data
	logic [2:0]   ev;                     // Events this cycle
	logic         start_req;              // Software start
	logic         stop_req;               // Software stop

	// Access list: walks the test sequence in its fixed order
	always_comb begin
		s_rd   = 1'b0;
		s_addr = RA_CMD;
		s_data = REG_RST;
		case (step_reg)
			4'd0: begin
				s_addr = RA_MASK;
				s_data = MASK_VAL;
			end
			4'd1: s_data = CMD_OFF;
			4'd2: begin
				s_addr = RA_CHAN;
				s_data = chan_reg;
			end
			4'd3: begin
				s_addr = RA_RFCTL;
				s_data = {pwrl_reg[7:2], GAIN_OFFS};
			end
			4'd4: begin
				s_rd   = 1'b1;
				s_addr = RA_STATUS;
			end
			4'd5: begin
				s_addr = RA_CFG_B;
				s_data = CFG_B_VAL;
			end
			4'd6: begin
				s_addr = RA_TEST;
				s_data = TEST_V1;
			end
			4'd7: begin
				s_addr = RA_TEST;
				s_data = TEST_V2;
			end
			4'd8: begin
				s_addr = RA_CFG_A;
				s_data = CFG_A_VAL;
			end
			4'd9: begin
				s_addr = RA_CFG_C;
				s_data = CFG_C_VAL;
			end
			4'd10: s_data = CMD_PLL;
			4'd11: begin
				s_rd   = 1'b1;
				s_addr = RA_ISTAT;
			end
			4'd12: s_data = CMD_TX;
			default: ;
		endcase
	end

	// Sequencer and software port next values
	always_comb begin
		ph_next    = ph_reg;
		step_next  = step_reg;
		rcnt_next  = rcnt_reg;
		chan_next  = chan_reg;
		pwr_next   = pwr_reg;
		pwrl_next  = pwrl_reg;
		imask_next = imask_reg;
		ord_next   = REG_RST;
		a_next     = a_reg;
		d_next     = d_reg;
		wr_next    = 1'b0;
		rd_next    = 1'b0;
		drst_next  = 1'b0;
		ev         = 3'h0;
		start_req  = i_wr && i_addr == HA_CTRL && i_wdata[0];
		stop_req   = i_wr && i_addr == HA_CTRL && i_wdata[1];
		// Software writes
		if (i_wr) begin
			case (i_addr)
				HA_CHAN:  chan_next  = i_wdata;
				HA_PWR:   pwr_next   = i_wdata;
				HA_IMASK: imask_next = i_wdata[2:0];
				default: ;
			endcase
		end
		// Phase machine
		case (ph_reg)
			H_IDLE: begin
				if (start_req) begin
					ph_next   = H_ISSUE;
					step_next = 4'd0;
					pwrl_next = pwr_reg;
				end
			end
			H_ISSUE: begin
				// One device access per step
				a_next  = s_addr;
				d_next  = s_data;
				wr_next = !s_rd;
				rd_next = s_rd;
				if (s_rd) begin
					ph_next = H_CHECK;
				end else if (step_reg == S_LAST) begin
					ph_next = H_TX;
					ev[EV_TX] = 1'b1;
				end else begin
					step_next = step_reg + 4'd1;
				end
			end
			H_CHECK: begin
				// Read data stands only in this cycle
				if (!rd_reg) begin
					ph_next = H_ISSUE;
					if (step_reg == S_VERIFY) begin
						if (bus.rdata == ST_OFF) begin
							step_next = step_reg + 4'd1;
						end else begin
							ph_next   = H_IDLE;
							ev[EV_ERR] = 1'b1;
						end
					end else if ((bus.rdata & LOCK_BIT) != REG_RST) begin
						step_next = step_reg + 4'd1;
					end
				end
			end
			H_TX: begin
				// Power latched, never rewritten while sending
				if (stop_req) begin
					a_next    = RA_TEST;
					d_next    = TEST_OFF;
					wr_next   = 1'b1;
					ph_next   = H_RST;
					rcnt_next = DRST_CYC;
				end
			end
			H_RST: begin
				drst_next = 1'b1;
				if (rcnt_reg <= 4'h1) begin
					ph_next = H_IDLE;
					ev[EV_DONE] = 1'b1;
				end else begin
					rcnt_next = rcnt_reg - 4'h1;
				end
			end
			default: ph_next = H_IDLE;
		endcase
		// Sticky events clear on read, new events win
		ist_next = ist_reg;
		if (i_rd && i_addr == HA_ISTAT) begin
			ist_next = 3'h0;
		end
		ist_next = ist_next | ev;
		irq_next = |(ist_next & imask_next);
		// Software reads
		if (i_rd) begin
			case (i_addr)
				HA_CHAN:  ord_next = chan_reg;
				HA_PWR:   ord_next = pwr_reg;
				HA_STAT:  ord_next = {5'h00, ph_reg};
				HA_ISTAT: ord_next = {5'h00, ist_reg};
				HA_IMASK: ord_next = {5'h00, imask_reg};
				default:  ord_next = REG_RST;
			endcase
		end
	end

	// Register stage
	always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			ph_reg    <= H_IDLE;
			step_reg  <= 4'h0;
			rcnt_reg  <= 4'h0;
			chan_reg  <= REG_RST;
			pwr_reg   <= REG_RST;
			pwrl_reg  <= REG_RST;
			ist_reg   <= 3'h0;
			imask_reg <= 3'h0;
			ord_reg   <= REG_RST;
			irq_reg   <= 1'b0;
			a_reg     <= REG_RST;
			d_reg     <= REG_RST;
			wr_reg    <= 1'b0;
			rd_reg    <= 1'b0;
			drst_reg  <= 1'b0;
		end else begin
			ph_reg    <= ph_next;
			step_reg  <= step_next;
			rcnt_reg  <= rcnt_next;
			chan_reg  <= chan_next;
			pwr_reg   <= pwr_next;
			pwrl_reg  <= pwrl_next;
			ist_reg   <= ist_next;
			imask_reg <= imask_next;
			ord_reg   <= ord_next;
			irq_reg   <= irq_next;
			a_reg     <= a_next;
			d_reg     <= d_next;
			wr_reg    <= wr_next;
			rd_reg    <= rd_next;
			drst_reg  <= drst_next;
		end
	end

	// Outputs straight from flops
	assign bus.addr    = a_reg;
	assign bus.wdata   = d_reg;
	assign bus.wr      = wr_reg;
	assign bus.rd      = rd_reg;
	assign bus.dev_rst = drst_reg;
	assign o_rdata     = ord_reg;
	assign o_irq       = irq_reg;
endmodule
`default_nettype wire

// ===== sim/cwts_chk.sv
// Purpose: Assertions on the register link between host and device.
// Assumes: One clock domain, asynchronous active-low reset.
// Notes:   Sees only the link signals, instantiated by the bench.
`timescale 1ns/100ps
`default_nettype none
module cwts_chk
	import cwts_pkg::*;
(
	input  wire logic       i_sys_clk,
	input  wire logic       i_rst_n,
	input  wire logic [7:0] addr,
	input  wire logic [7:0] wdata,
	input  wire logic       wr,
	input  wire logic       rd,
	input  wire logic       dev_rst,
	input  wire logic [7:0] rdata,
	input  wire logic       irq
);
	logic tx_on_reg;     // Transmit commanded, no device reset since
	logic tx_on_next;    // Next value of tx_on_reg
	logic off_seen_reg;  // Test-off write seen since last device reset
	logic off_seen_next; // Next value of off_seen_reg
	default clocking cb @(posedge i_sys_clk);
	endclocking
	default disable iff (!i_rst_n);
	// Track transmit start and test-off writes
	always_comb begin
		tx_on_next = tx_on_reg;
		off_seen_next = off_seen_reg;
		if (dev_rst) begin
			tx_on_next = 1'b0;
			off_seen_next = 1'b0;
		end else if (wr && addr == RA_CMD && wdata == CMD_TX) begin
			tx_on_next = 1'b1;
		end else if (wr && addr == RA_TEST && wdata == TEST_OFF) begin
			off_seen_next = 1'b1;
		end
	end
	// Register the trackers
	always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			tx_on_reg <= 1'b0;
			off_seen_reg <= 1'b0;
		end else begin
			tx_on_reg <= tx_on_next;
			off_seen_reg <= off_seen_next;
		end
	end
	// Steps of the sequence
	sequence s_off_cmd;
		wr && addr == RA_CMD && wdata == CMD_OFF;
	endsequence
	sequence s_off_read;
		s_off_cmd ##1 wr ##1 wr ##1 rd && addr == RA_STATUS;
	endsequence
	sequence s_pll_cmd;
		wr && addr == RA_CMD && wdata == CMD_PLL;
	endsequence
	sequence s_cfg;
		wr && addr == RA_CFG_B && wdata == CFG_B_VAL ##1
		wr && addr == RA_TEST && wdata == TEST_V1 ##1
		wr && addr == RA_TEST && wdata == TEST_V2 ##1
		wr && addr == RA_CFG_A && wdata == CFG_A_VAL ##1
		wr && addr == RA_CFG_C && wdata == CFG_C_VAL ##1 s_pll_cmd;
	endsequence
	property p_one_strobe;
		!(wr && rd);
	endproperty
	property p_rdata_idle;
		!rd |=> rdata == 8'h00;
	endproperty
	property p_mask_first;
		s_off_cmd |-> $past(wr) && $past(addr) == RA_MASK &&
			$past(wdata) == MASK_VAL;
	endproperty
	property p_chan_pwr;
		s_off_cmd |=> wr && addr == RA_CHAN ##1
			wr && addr == RA_RFCTL && wdata[1:0] == GAIN_OFFS;
	endproperty
	property p_off_state;
		s_off_read |=> rdata == ST_OFF;
	endproperty
	// The host spends a quiet issue cycle after the read answer
	property p_cfg_order;
		rd && addr == RA_STATUS ##1 rdata == ST_OFF |=>
			!wr && !rd ##1 s_cfg;
	endproperty
	property p_lock_irq;
		s_pll_cmd |=> !irq [*8] ##[1:60] irq;
	endproperty
	property p_tx_after_lock;
		wr && addr == RA_CMD && wdata == CMD_TX |->
			$past(rdata) == LOCK_BIT || $past(rdata, 2) == LOCK_BIT;
	endproperty
	property p_rst_after_off;
		$rose(dev_rst) |-> off_seen_reg;
	endproperty
	property p_rst_len;
		$rose(dev_rst) |-> dev_rst [*4] ##1 !dev_rst;
	endproperty
	property p_pwr_hold;
		wr && tx_on_reg |-> addr != RA_RFCTL;
	endproperty
	a_one_strobe: assert property (p_one_strobe)
		else $error("read and write strobes together");
	a_rdata_idle: assert property (p_rdata_idle)
		else $error("read data not zero outside read answer");
	a_mask_first: assert property (p_mask_first)
		else $error("mask write did not precede off command");
	a_chan_pwr: assert property (p_chan_pwr)
		else $error("channel and power writes out of order");
	a_off_state: assert property (p_off_state)
		else $error("status after off command not off");
	a_cfg_order: assert property (p_cfg_order)
		else $error("test configuration writes wrong");
	a_lock_irq: assert property (p_lock_irq)
		else $error("lock interrupt timing wrong");
	a_tx_after_lock: assert property (p_tx_after_lock)
		else $error("transmit started without lock");
	a_rst_after_off: assert property (p_rst_after_off)
		else $error("device reset without test-off write");
	a_rst_len: assert property (p_rst_len)
		else $error("device reset pulse length wrong");
	a_pwr_hold: assert property (p_pwr_hold)
		else $error("power written during transmission");
endmodule
`default_nettype wire

// ===== sim/cw_test_mode_sequencer_tb.sv
// Purpose: Self-checking bench for the host and device pair.
// Assumes: 40 MHz clock, software port driven at rising edges.
// Notes:   A monitor logs every link write for order checks.
`timescale 1ns/100ps
`default_nettype none
module cw_test_mode_sequencer_tb;
	import cwts_pkg::*;
	logic        i_sys_clk;       // System clock
	logic        i_rst_n;         // Reset, active low
	logic [2:0]  i_addr;          // Software address
	logic [7:0]  i_wdata;         // Software write data
	logic        i_wr;            // Software write strobe
	logic        i_rd;            // Software read strobe
	logic [7:0]  o_rdata;         // Software read data
	logic        o_irq;           // Host interrupt
	logic        o_cw_active;     // Carrier on
	logic [7:0]  o_channel;       // Device channel
	cwts_radio_t o_radio_state;   // Device state
	logic [15:0] wlog[$];         // Logged link writes
	int          rst_cyc = 0;     // Cycles with device reset high
	int          miscompares = 0; // Mismatches
	int          n_compared = 0;  // Comparisons
	cwts_if bus ();
	cwts_host i_cwts_host (.i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n),
		.bus(bus), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr),
		.i_rd(i_rd), .o_rdata(o_rdata), .o_irq(o_irq));
	cwts_device i_cwts_device (.i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n),
		.bus(bus), .o_cw_active(o_cw_active), .o_channel(o_channel),
		.o_radio_state(o_radio_state));
	cwts_chk i_cwts_chk (.i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n),
		.addr(bus.addr), .wdata(bus.wdata), .wr(bus.wr), .rd(bus.rd),
		.dev_rst(bus.dev_rst), .rdata(bus.rdata), .irq(bus.irq));
	// Clock
	initial begin
		i_sys_clk = 1'b0;
		forever #12.5 i_sys_clk = ~i_sys_clk;
	end
	// Log link writes and count device reset cycles
	always @(posedge i_sys_clk) begin
		if (bus.wr === 1'b1) wlog.push_back({bus.addr, bus.wdata});
		if (bus.dev_rst === 1'b1) rst_cyc++;
	end
	// Compare one value
	task automatic chk(input logic [15:0] got, input logic [15:0] exp,
		input string what);
		n_compared++;
		if (got !== exp) begin
			miscompares++;
			$display("BAD %0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask
	// Software write, one strobe cycle
	task automatic sw_wr(input logic [2:0] a, input logic [7:0] d);
		@(posedge i_sys_clk);
		i_wr <= 1'b1;
		i_addr <= a;
		i_wdata <= d;
		@(posedge i_sys_clk);
		i_wr <= 1'b0;
	endtask
	// Software read, data judged in the cycle after the strobe
	task automatic sw_rd(input logic [2:0] a, input logic [7:0] exp,
		input string what);
		@(posedge i_sys_clk);
		i_rd <= 1'b1;
		i_addr <= a;
		@(posedge i_sys_clk);
		i_rd <= 1'b0;
		@(negedge i_sys_clk);
		chk(o_rdata, exp, what);
	endtask
	// Bounded wait for the host interrupt
	task automatic wait_irq(input int lim);
		int n;
		n = 0;
		while (o_irq !== 1'b1 && n < lim) begin
			@(posedge i_sys_clk);
			n++;
		end
		// Let the logger see that edge before anything is judged
		@(negedge i_sys_clk);
		chk(o_irq, 1'b1, "irq");
	endtask
	// Compare the logged start sequence
	task automatic seq_chk(input logic [7:0] ch, input logic [7:0] pw);
		logic [15:0] exp [11];
		exp = '{16'h0E01, 16'h0203, {8'h08, ch}, {8'h16, pw[7:2], 2'b11},
			16'h360F, 16'h1C54, 16'h1C42, 16'h3400, 16'h3F08, 16'h0209,
			16'h0202};
		chk(16'(wlog.size()), 16'd11, "write count");
		foreach (exp[i]) chk(wlog[i], exp[i], "link write");
	endtask
	// Reset values, read back, unmapped and mask width
	task automatic t_regs();
		sw_rd(HA_STAT, 8'h00, "stat reset");
		sw_rd(HA_ISTAT, 8'h00, "istat reset");
		sw_rd(HA_CHAN, 8'h00, "chan reset");
		sw_wr(HA_CHAN, 8'h5A);
		sw_wr(HA_PWR, 8'hB4);
		sw_wr(HA_IMASK, 8'hFF);
		sw_rd(HA_CHAN, 8'h5A, "chan");
		sw_rd(HA_PWR, 8'hB4, "pwr");
		sw_rd(HA_IMASK, 8'h07, "imask");
		sw_rd(3'h6, 8'h00, "unmapped");
		sw_rd(HA_CTRL, 8'h00, "ctrl");
		sw_wr(HA_IMASK, 8'h00);
		$display("done t_regs");
	endtask
	// Start with events masked, then unmask the pending event
	task automatic t_start();
		int n;
		n = 0;
		wlog.delete();
		sw_wr(HA_CTRL, 8'h01);
		while (o_radio_state !== BUSY_TX && n < 300) begin
			@(posedge i_sys_clk);
			n++;
		end
		repeat (3) @(posedge i_sys_clk);
		chk(o_radio_state, BUSY_TX, "state");
		chk(o_cw_active, 1'b1, "carrier");
		chk(o_channel, 8'h5A, "channel");
		chk(o_irq, 1'b0, "masked irq");
		sw_rd(HA_STAT, 8'h03, "phase tx");
		seq_chk(8'h5A, 8'hB4);
		sw_wr(HA_IMASK, 8'h01);
		@(negedge i_sys_clk);
		chk(o_irq, 1'b1, "unmasked irq");
		sw_rd(HA_ISTAT, 8'h01, "istat tx");
		sw_rd(HA_ISTAT, 8'h00, "istat cleared");
		chk(o_irq, 1'b0, "irq cleared");
		$display("done t_start");
	endtask
	// Power change and second start during transmission
	task automatic t_hold();
		wlog.delete();
		sw_wr(HA_PWR, 8'h10);
		sw_wr(HA_CTRL, 8'h01);
		repeat (20) @(posedge i_sys_clk);
		chk(16'(wlog.size()), 16'd0, "writes in tx");
		chk(o_cw_active, 1'b1, "carrier held");
		sw_rd(HA_PWR, 8'h10, "pwr");
		$display("done t_hold");
	endtask
	// Stop, test off, device reset; stop in idle is ignored
	task automatic t_stop();
		wlog.delete();
		rst_cyc = 0;
		sw_wr(HA_IMASK, 8'h02);
		sw_wr(HA_CTRL, 8'h02);
		wait_irq(100);
		chk(16'(wlog.size()), 16'd1, "stop writes");
		chk(wlog[0], 16'h1C00, "test off");
		chk(16'(rst_cyc), 16'd4, "reset cycles");
		chk(o_radio_state, RADIO_OFF_STATE, "state off");
		chk(o_cw_active, 1'b0, "carrier off");
		chk(o_channel, 8'h00, "channel reset");
		sw_rd(HA_STAT, 8'h00, "phase idle");
		sw_rd(HA_ISTAT, 8'h02, "istat done");
		chk(o_irq, 1'b0, "irq cleared");
		sw_wr(HA_CTRL, 8'h02);
		repeat (10) @(posedge i_sys_clk);
		chk(16'(wlog.size()), 16'd1, "stop in idle");
		$display("done t_stop");
	endtask
	// Second run uses the power written during transmission
	task automatic t_rerun();
		wlog.delete();
		sw_wr(HA_IMASK, 8'h01);
		sw_wr(HA_CTRL, 8'h01);
		wait_irq(300);
		seq_chk(8'h5A, 8'h10);
		chk(o_radio_state, BUSY_TX, "state");
		sw_rd(HA_ISTAT, 8'h01, "istat tx");
		$display("done t_rerun");
	endtask
	// Verdict
	task automatic finish_test();
		$display("compared %0d mismatches %0d", n_compared, miscompares);
		if (miscompares == 0 && n_compared > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask
	// Watchdog, far beyond the expected run
	initial begin
		#125000;
		miscompares++;
		$display("BAD %0t watchdog", $time);
		finish_test();
	end
	// Main sequence
	initial begin
		i_rst_n = 1'b0;
		i_addr = 3'h0;
		i_wdata = 8'h00;
		i_wr = 1'b0;
		i_rd = 1'b0;
		repeat (8) @(posedge i_sys_clk);
		i_rst_n <= 1'b1;
		t_regs();
		t_start();
		t_hold();
		t_stop();
		t_rerun();
		finish_test();
	end
endmodule
`default_nettype wire
